// file: verilog/lcd_drive_defs.vh
// Purpose: Shared constants for the LCD segment driver
// Assumes: 8-bit register address, 4-bit register data
// Notes: Level codes name the four drive potentials, ground first
`ifndef LCD_DRIVE_DEFS_VH
`define LCD_DRIVE_DEFS_VH

// Register map
`define LCD_ADDR_CTRL 8'hFB
`define LCD_ADDR_MEM_FIRST 8'h90
`define LCD_ADDR_MEM_LAST 8'hAF
`define LCD_ADDR_STATUS 8'hFE

// Control word fields
`define LCD_BIT_STATIC 3
`define LCD_BIT_BLANK 2
`define LCD_BIT_LIGHT 1
`define LCD_RST_STATIC 1'h0
`define LCD_RST_BLANK 1'h1
`define LCD_RST_LIGHT 1'h0

// Drive level codes
`define LCD_LVL_GND 2'h0
`define LCD_LVL_LOW 2'h1
`define LCD_LVL_MID 2'h2
`define LCD_LVL_HIGH 2'h3

// Frame dividers, oscillator cycles per frame
`define LCD_DIV_LOWF_FULL 1024
`define LCD_DIV_LOWF_THIRD 768
`define LCD_DIV_RC_FULL 6144
`define LCD_DIV_RC_THIRD 4608
`define LCD_DIV_CER_FULL 12288
`define LCD_DIV_CER_THIRD 9216

// Oscillator variants
`define LCD_OSC_LOWF 0
`define LCD_OSC_RC 1
`define LCD_OSC_CER 2

`endif

// file: verilog/frame_divider.v
// Purpose: Common scan and frame signal timing
// Assumes: SLOT_LEN clocks per common slot, DUTY slots per half frame
// Notes: Frame signal toggles after each full scan, so its period is 2*DUTY*SLOT_LEN
module frame_divider #(
  parameter SLOT_LEN = 128,
  parameter DUTY = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Timing outputs
  output reg [1:0] commonIdx,
  output reg frameSig
);

  reg [15:0] slotCnt_r;

  always @(posedge clk)
  begin
    if (rst)
    begin
      slotCnt_r <= 16'h0000;
      commonIdx <= 2'h0;
      frameSig <= 1'b0;
    end
    else if (slotCnt_r == SLOT_LEN[15:0] - 16'h0001)
    begin
      slotCnt_r <= 16'h0000;
      // Toggling once per scan keeps the glass free of DC bias
      if (commonIdx == DUTY[1:0] - 2'h1 || (DUTY == 4 && commonIdx == 2'h3))
      begin
        commonIdx <= 2'h0;
        frameSig <= ~frameSig;
      end
      else
      begin
        commonIdx <= commonIdx + 2'h1;
      end
    end
    else
    begin
      slotCnt_r <= slotCnt_r + 16'h0001;
    end
  end

endmodule

// file: verilog/lcd_segment_driver.v
// Purpose: Multiplexed LCD driver with four commons and 26 segment outputs
// Assumes: clk is the oscillator clock; sleepReq comes from logic on clk
// Notes: Pins are given as 2-bit level codes; the analog stage maps them to potentials
`include "lcd_drive_defs.vh"

module lcd_segment_driver #(
  parameter DUTY = 4,
  parameter OSC_VARIANT = `LCD_OSC_LOWF,
  parameter INTERNAL_SUPPLY = 1,
  parameter DIV_RC_FULL = `LCD_DIV_RC_FULL,
  parameter DIV_RC_THIRD = `LCD_DIV_RC_THIRD,
  parameter DIV_CER_FULL = `LCD_DIV_CER_FULL,
  parameter DIV_CER_THIRD = `LCD_DIV_CER_THIRD,
  parameter [12:0] DC_PAIRS = 13'h0000,
  parameter [25:0] OPEN_DRAIN = 26'h0000000,
  parameter [727:0] SEG_MAP = identity_map(1'b0)
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [7:0] addr,
  input wire [3:0] wrData,
  input wire wrStb,
  input wire rdStb,
  output reg [3:0] rdData,
  // System state
  input wire sleepReq,
  // Panel drive, two bits per common and segment pin, one bit of frame signal
  output reg [7:0] commonOutputs,
  output reg [51:0] segmentOutputs,
  output reg frameSignal,
  // DC outputs, one bit per segment pin
  output reg [25:0] dcOut,
  output reg [25:0] dcOe,
  // Drive-level supply enables
  output reg driveLevelLow,
  output reg driveLevelMid,
  output reg driveLevelHigh
);

  // Default map: segment n uses word n, bit equal to the common number
  function [727:0] identity_map;
    input dummy;
    integer s;
    integer c;
    begin
      identity_map = 728'h0;
      for (s = 0; s < 26; s = s + 1)
        for (c = 0; c < 4; c = c + 1)
          identity_map[(s * 4 + c) * 7 +: 7] = {s[4:0], c[1:0]};
    end
  endfunction

  // Map lookup: word address and bit for a segment and common
  function [6:0] map_entry;
    input integer s;
    input integer c;
    begin
      map_entry = SEG_MAP[(s * 4 + c) * 7 +: 7];
    end
  endfunction

  // Level of a common pin for the current frame half
  function [1:0] com_level;
    input selected;
    input frame;
    input isStatic;
    begin
      if (isStatic)
        com_level = frame ? `LCD_LVL_GND : `LCD_LVL_HIGH;
      else if (selected)
        com_level = frame ? `LCD_LVL_GND : `LCD_LVL_HIGH;
      else
        com_level = frame ? `LCD_LVL_MID : `LCD_LVL_LOW;
    end
  endfunction

  // Level of a segment pin; on is opposite the selected common
  function [1:0] seg_level;
    input on;
    input frame;
    input isStatic;
    begin
      if (isStatic)
        seg_level = (on ^ frame) ? `LCD_LVL_GND : `LCD_LVL_HIGH;
      else if (on)
        seg_level = frame ? `LCD_LVL_HIGH : `LCD_LVL_GND;
      else
        seg_level = frame ? `LCD_LVL_LOW : `LCD_LVL_MID;
    end
  endfunction

  // Address decode, shared by the write and read paths
  function is_mem_addr;
    input [7:0] a;
    begin
      is_mem_addr = (a >= `LCD_ADDR_MEM_FIRST) && (a <= `LCD_ADDR_MEM_LAST);
    end
  endfunction

  function is_ctrl_addr;
    input [7:0] a;
    begin
      is_ctrl_addr = (a == `LCD_ADDR_CTRL);
    end
  endfunction

  // Word index in display memory; the offset is cut to five bits on purpose
  function [4:0] mem_index;
    input [7:0] a;
    reg [7:0] off;
    begin
      off = a - `LCD_ADDR_MEM_FIRST;
      mem_index = off[4:0];
    end
  endfunction

  // Split a map entry into its display word and bit
  function [4:0] entry_word;
    input [6:0] e;
    begin
      entry_word = e[6:2];
    end
  endfunction

  function [1:0] entry_bit;
    input [6:0] e;
    begin
      entry_bit = e[1:0];
    end
  endfunction

  // Frame divide for the configured variant and duty
  localparam DIV_FULL = (OSC_VARIANT == `LCD_OSC_RC) ? DIV_RC_FULL :
    (OSC_VARIANT == `LCD_OSC_CER) ? DIV_CER_FULL : `LCD_DIV_LOWF_FULL;
  localparam DIV_THIRD = (OSC_VARIANT == `LCD_OSC_RC) ? DIV_RC_THIRD :
    (OSC_VARIANT == `LCD_OSC_CER) ? DIV_CER_THIRD : `LCD_DIV_LOWF_THIRD;
  localparam FRAME_DIV = (DUTY == 3) ? DIV_THIRD : DIV_FULL;
  localparam SLOT_LEN = FRAME_DIV / (2 * DUTY);

  reg [3:0] dispMem_r [0:31];
  reg staticSel_r;
  reg blankAll_r;
  reg lightAll_r;
  wire [1:0] commonIdx;
  wire frameSig;
  wire sleepActive;
  wire memWrite;
  wire [4:0] memIdx;
  reg [7:0] comNxt;
  reg [51:0] segNxt;
  reg [25:0] dcOutNxt;
  reg [25:0] dcOeNxt;
  reg [3:0] rdNxt;
  reg onBit;
  reg [6:0] ent;
  integer s;
  integer c;
  // Reset fill has its own counters so no variable is written by two processes
  integer rs;
  integer rc;

  // Slot and frame timing; the pins follow it one edge later
  frame_divider #(
    .SLOT_LEN(SLOT_LEN),
    .DUTY(DUTY)
  ) u_frame_divider (
    .clk(clk),
    .rst(rst),
    .commonIdx(commonIdx),
    .frameSig(frameSig)
  );

  // Sleep only acts with the internal supply; external supply cannot sleep
  assign sleepActive = sleepReq & (INTERNAL_SUPPLY != 0);
  assign memWrite = wrStb && is_mem_addr(addr);
  assign memIdx = mem_index(addr);

  // Control word
  always @(posedge clk)
  begin
    if (rst)
    begin
      staticSel_r <= `LCD_RST_STATIC;
      blankAll_r <= `LCD_RST_BLANK;
      lightAll_r <= `LCD_RST_LIGHT;
    end
    else if (wrStb && is_ctrl_addr(addr))
    begin
      staticSel_r <= wrData[`LCD_BIT_STATIC];
      blankAll_r <= wrData[`LCD_BIT_BLANK];
      lightAll_r <= wrData[`LCD_BIT_LIGHT];
    end
  end

  // Display memory; reset sets the bits of DC-pair pins to one, other words keep whatever they held
  always @(posedge clk)
  begin
    if (rst)
    begin
      for (rs = 0; rs < 26; rs = rs + 1)
        if (DC_PAIRS[rs / 2])
          for (rc = 0; rc < 4; rc = rc + 1)
            dispMem_r[entry_word(map_entry(rs, rc))][entry_bit(map_entry(rs, rc))] <= 1'b1;
    end
    else if (memWrite)
    begin
      // Outside reset only the bus writes the array; the display overrides never touch it
      dispMem_r[memIdx] <= wrData;
    end
  end

  // Read port: display memory is not readable, so it reads as zero
  always @*
  begin
    rdNxt = 4'h0;
    if (is_ctrl_addr(addr))
    begin
      rdNxt[`LCD_BIT_STATIC] = staticSel_r;
      rdNxt[`LCD_BIT_BLANK] = blankAll_r;
      rdNxt[`LCD_BIT_LIGHT] = lightAll_r;
      rdNxt[0] = 1'b0;
    end
    else if (addr == `LCD_ADDR_STATUS)
    begin
      rdNxt = {sleepActive, frameSig, commonIdx};
    end
    else if (is_mem_addr(addr))
    begin
      rdNxt = 4'h0;
    end
  end

  // Read data falls back to zero so a stale word is never taken twice
  always @(posedge clk)
  begin
    if (rst)
      rdData <= 4'h0;
    else if (rdStb)
      rdData <= rdNxt;
    else
      rdData <= 4'h0;
  end

  // Pin levels for the current slot, taken by the pins on the next edge
  always @*
  begin
    comNxt = 8'h00;
    segNxt = 52'h0;
    dcOutNxt = 26'h0;
    dcOeNxt = 26'h0;
    onBit = 1'b0;
    ent = 7'h00;
    for (c = 0; c < 4; c = c + 1)
      comNxt[c * 2 +: 2] = com_level(c < DUTY && c == commonIdx, frameSig, staticSel_r);
    for (s = 0; s < 26; s = s + 1)
    begin
      if (DC_PAIRS[s / 2])
      begin
        ent = map_entry(s, 0);
        onBit = dispMem_r[entry_word(ent)][entry_bit(ent)];
        if (OPEN_DRAIN[s])
        begin
          dcOutNxt[s] = 1'b0;
          dcOeNxt[s] = ~onBit;
        end
        else
        begin
          dcOutNxt[s] = onBit;
          dcOeNxt[s] = 1'b1;
        end
      end
      else
      begin
        // Static always reads the fourth-common bit, whatever the duty
        ent = staticSel_r ? map_entry(s, 3) : map_entry(s, commonIdx);
        onBit = dispMem_r[entry_word(ent)][entry_bit(ent)];
        // Blank-all is tested first so it wins over light-all
        if (blankAll_r)
          onBit = 1'b0;
        else if (lightAll_r)
          onBit = 1'b1;
        segNxt[s * 2 +: 2] = seg_level(onBit, frameSig, staticSel_r);
      end
    end
    if (sleepActive)
    begin
      comNxt = 8'h00;
      segNxt = 52'h0;
    end
  end

  // Registered pins change only on clock edges, so the glass never sees a glitch
  always @(posedge clk)
  begin
    if (rst)
    begin
      commonOutputs <= 8'h00;
      segmentOutputs <= 52'h0;
      frameSignal <= 1'b0;
      dcOut <= 26'h0;
      dcOe <= 26'h0;
      driveLevelLow <= 1'b0;
      driveLevelMid <= 1'b0;
      driveLevelHigh <= 1'b0;
    end
    else
    begin
      commonOutputs <= comNxt;
      segmentOutputs <= segNxt;
      frameSignal <= frameSig;
      dcOut <= dcOutNxt;
      dcOe <= dcOeNxt;
      driveLevelLow <= ~sleepActive;
      driveLevelMid <= ~sleepActive;
      driveLevelHigh <= ~sleepActive;
    end
  end

endmodule

// file: tb/lcd_panel_model.sv
// Purpose: LCD glass model, reports segments under full drive
// Assumes: level codes 0..3, a selected common sits at 0 or 3
// Notes: static drive selects every common, so selIdx reads 0 there
module lcd_panel_model (
  // Driver pins
  input wire logic [7:0] commonOutputs,
  input wire logic [51:0] segmentOutputs,
  // Seen state
  output logic [25:0] litNow,
  output logic [1:0] selIdx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cl;
  always_comb
  begin
    litNow = '0;
    selIdx = 2'h0;
    for (int c = 3; c >= 0; c--)
    begin
      cl = commonOutputs[2*c +: 2];
      if (cl == 2'h0 || cl == 2'h3)
        selIdx = 2'(c);
      // Only ground against top level darkens a dot; 1 against 2 does not
      for (int s = 0; s < 26; s++)
        if ({cl, segmentOutputs[2*s +: 2]} inside {4'hC, 4'h3})
          litNow[s] = 1'b1;
    end
  end
endmodule

// file: tb/lcd_drive_checker.sv
// Purpose: Port properties of the LCD segment driver
// Assumes: 1/4 duty, low-frequency divider, internal supply
// Notes: control bits mirrored from bus writes, having no pin
module lcd_drive_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [3:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [3:0] rdData,
  // Panel and supply
  input wire logic sleepReq,
  input wire logic [7:0] commonOutputs,
  input wire logic [51:0] segmentOutputs,
  input wire logic frameSignal,
  input wire logic driveLevelLow,
  input wire logic driveLevelMid,
  input wire logic driveLevelHigh
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 512;
  logic [3:0] ctrl_r;
  logic [9:0] cnt_r;
  logic prevFr_r, seen_r;
  logic [25:0] lit;
  always_comb
  begin
    lit = '0;
    for (int c = 0; c < 4; c++)
      for (int s = 0; s < 26; s++)
        if ({commonOutputs[2*c +: 2], segmentOutputs[2*s +: 2]} inside {4'hC, 4'h3})
          lit[s] = 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_r <= 4'h4;
    else if (wrStb && addr == 8'hFB)
      ctrl_r <= wrData;
    prevFr_r <= frameSignal;
    cnt_r <= (rst || sleepReq || frameSignal != prevFr_r) ? 10'h0 : cnt_r + 10'h1;
    // First toggle after sleep or reset may be partial
    if (rst || sleepReq)
      seen_r <= 1'b0;
    else if (frameSignal != prevFr_r)
      seen_r <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  mem_read_zero_a: assert property (rdStb && addr inside {[8'h90:8'hAF]} |=> rdData == 4'h0)
    else $error("display memory read gave data");
  ctrl_d0_zero_a: assert property (rdStb && addr == 8'hFB |=> !rdData[0])
    else $error("control bit 0 read as one");
  ctrl_echo_a: assert property (rdStb && addr == 8'hFB |=> rdData == ($past(ctrl_r) & 4'hE))
    else $error("control word read back wrong");
  blank_dark_a: assert property (ctrl_r[2] [*3] |-> lit == 26'h0)
    else $error("segment lit while blanked");
  light_full_a: assert property ((!ctrl_r[2] && ctrl_r[1] && !sleepReq) [*3] |-> &lit)
    else $error("segment dark while all lit");
  frame_half_a: assert property (seen_r && frameSignal != prevFr_r |-> cnt_r == HALF - 1)
    else $error("frame half period wrong");
  sleep_dark_a: assert property (sleepReq [*3] |-> !(driveLevelLow || driveLevelMid || driveLevelHigh)
    && commonOutputs == 8'h0 && segmentOutputs == 52'h0)
    else $error("levels not grounded in sleep");
  awake_on_a: assert property (!sleepReq [*3] |-> driveLevelLow && driveLevelMid && driveLevelHigh)
    else $error("drive supply off while awake");
  cover property (ctrl_r[1] && !ctrl_r[2]);
  cover property (ctrl_r[3] && !ctrl_r[2]);
  cover property (sleepReq [*3]);
endmodule

// file: tb/tb.sv
// Purpose: Self-checking bench for the LCD segment driver
// Assumes: default build, word n feeds segment n, bit = common
// Notes: reads and pin looks are noted in queues, a monitor compares
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, wrStb = 1'b0, rdStb = 1'b0, sleepReq = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] wrData = 4'h0, rdData;
  logic [7:0] commonOutputs;
  logic [51:0] segmentOutputs;
  logic [25:0] litNow;
  logic [1:0] selIdx;
  logic [25:0] dcOut, dcOe, litExp;
  logic [3:0] rdExp;
  logic [51:0] dcExp;
  logic [3:0] mem [0:25];
  logic [3:0] rdQ [$];
  logic [25:0] litQ [$];
  logic [51:0] dcQ [$];
  logic rdPend = 1'b0, litReq = 1'b0, blank = 1'b1, light = 1'b0, stat = 1'b0, slp = 1'b0;
  int errCount = 0, testsRun = 0, cycN = 0, seed = 32'h9E33;
`define CHK(got, exp) \
  begin testsRun++; if ((got) !== (exp)) begin errCount++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
  lcd_segment_driver dut_u (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .sleepReq(sleepReq), .commonOutputs(commonOutputs), .segmentOutputs(segmentOutputs),
    .frameSignal(), .dcOut(dcOut), .dcOe(dcOe), .driveLevelLow(), .driveLevelMid(), .driveLevelHigh());
  lcd_panel_model panel_u (.commonOutputs(commonOutputs), .segmentOutputs(segmentOutputs), .litNow(litNow),
    .selIdx(selIdx));
  always #20 clk = ~clk;
  task automatic report_and_stop();
    if (errCount == 0 && testsRun > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (rdPend)
    begin
      rdExp = rdQ.pop_front();
      `CHK(rdData, rdExp)
    end
    if (litReq)
    begin
      litExp = litQ.pop_front();
      dcExp = dcQ.pop_front();
      `CHK(litNow, litExp)
      `CHK({dcOe, dcOut}, dcExp)
    end
    rdPend <= rdStb;
    cycN++;
    if (cycN == 20000)
    begin
      errCount++;
      report_and_stop();
    end
  end
  task automatic cyc(input logic w, r, input logic [7:0] a, input logic [3:0] d, e);
    wrStb <= w;
    rdStb <= r;
    addr <= a;
    wrData <= d;
    if (r)
      rdQ.push_back(e);
    @(posedge clk);
  endtask
  // Pins trail a write by two edges, so settle before noting
  task automatic look();
    logic [25:0] e;
    wrStb <= 1'b0;
    rdStb <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    for (int s = 0; s < 26; s++)
      e[s] = slp ? 1'b0 : blank ? 1'b0 : light ? 1'b1 : stat ? mem[s][3] : mem[s][selIdx];
    litQ.push_back(e);
    dcQ.push_back(52'h0);
    litReq = 1'b1;
    @(negedge clk);
    litReq = 1'b0;
    @(posedge clk);
  endtask
  task automatic scan();
    repeat (4)
    begin
      look();
      repeat (123) @(posedge clk);
    end
  endtask
  task automatic setc(input logic b, l, st);
    blank = b;
    light = l;
    stat = st;
    cyc(1'b1, 1'b0, 8'hFB, {st, b, l, 1'b0}, 4'h0);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cyc(1'b0, 1'b1, 8'hFB, 4'h0, 4'h4);
    cyc(1'b0, 1'b1, 8'hC0, 4'h0, 4'h0);
    for (int n = 0; n < 26; n++)
    begin
      mem[n] = 4'($random(seed));
      cyc(1'b1, 1'b0, 8'h90 + 8'(n), mem[n], 4'h0);
    end
    cyc(1'b0, 1'b1, 8'h95, 4'h0, 4'h0);
    scan();
    setc(1'b0, 1'b1, 1'b0);
    scan();
    setc(1'b1, 1'b1, 1'b0);
    scan();
    setc(1'b0, 1'b0, 1'b0);
    scan();
    setc(1'b0, 1'b0, 1'b1);
    for (int n = 0; n < 26; n++)
    begin
      mem[n] = {mem[n][0], 3'h0};
      cyc(1'b1, 1'b0, 8'h90 + 8'(n), mem[n], 4'h0);
    end
    scan();
    for (int n = 0; n < 26; n++)
    begin
      mem[n] = {4{~mem[n][3]}};
      cyc(1'b1, 1'b0, 8'h90 + 8'(n), mem[n], 4'h0);
    end
    scan();
    cyc(1'b1, 1'b0, 8'hFB, 4'hF, 4'h0);
    cyc(1'b0, 1'b1, 8'hFB, 4'h0, 4'hE);
    rdStb <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    blank = 1'b1;
    light = 1'b0;
    stat = 1'b0;
    cyc(1'b0, 1'b1, 8'hFB, 4'h0, 4'h4);
    look();
    setc(1'b0, 1'b1, 1'b0);
    slp = 1'b1;
    sleepReq <= 1'b1;
    look();
    report_and_stop();
  end
endmodule
bind lcd_segment_driver lcd_drive_checker chk_u (.clk, .rst, .addr, .wrData, .wrStb, .rdStb, .rdData, .sleepReq,
  .commonOutputs, .segmentOutputs, .frameSignal, .driveLevelLow, .driveLevelMid, .driveLevelHigh);
